// *** tb/drp_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module drp_core_model
  import drp_pkg::*;
(
  // clock
  input wire logic clock,
  // special-register port
  output var drp_pkg::drp_sfr_req_t sfr_req,
  input wire logic [3:0] sfr_rdata_q,
  input wire logic sfr_rvalid_q
);
  import drp_pkg::*;

  initial sfr_req = '0;

  // one-cycle strobe; released strobes are low, released address and data show the inverse of what was sent
  task automatic put(input logic w, input logic r, input logic [4:0] a, input logic [3:0] d);
    @(negedge clock);
    sfr_req = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clock);
    sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic [4:0] a, input logic [3:0] d);
    put(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [4:0] a, output logic [3:0] q, output logic v);
    put(1'b0, 1'b1, a, 4'h0);
    q = sfr_rdata_q;
    v = sfr_rvalid_q;
  endtask

  task automatic set_addr(input logic [19:0] a);
    wr(DRP_OFF_NIB0, a[3:0]);
    wr(DRP_OFF_NIB1, a[7:4]);
    wr(DRP_OFF_NIB2, a[11:8]);
    wr(DRP_OFF_NIB3, a[15:12]);
    wr(DRP_OFF_TOP, {3'b101, a[16]});
    repeat (2) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// *** tb/drp_read_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module drp_read_port_tb;
  import drp_pkg::*;

  localparam int N = 5;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  drp_sfr_req_t sfr_req;
  drp_prog_t prog = '0;
  logic wdt_option_en = 1'b0;
  logic [3:0] sfr_rdata_q;
  logic sfr_rvalid_q;
  logic sfr_hit;
  logic wdt_reset_req;
  logic data_ready;
  logic sys_area;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  int wdt_hits = 0;
  logic [3:0] q;
  logic v;
  // address, programmed byte, expected byte, expected system-area flag
  logic [19:0] r_addr [N] = '{20'h0_0000, 20'h1_2345, 20'h1_dfbf, 20'h1_dfc0, 20'h1_e000};
  logic [7:0] r_byte [N] = '{8'h5a, 8'hc3, 8'h81, 8'h7e, 8'hab};
  logic [7:0] r_exp [N] = '{8'h5a, 8'hc3, 8'h81, 8'h7e, 8'h00};
  logic r_sys [N] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  always #4 clock = ~clock;

  drp_read_port #(.WDT_PERIOD_CYC(16)) u_drp_read_port (
    .clock(clock),
    .nrst(nrst),
    .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q),
    .sfr_rvalid_q(sfr_rvalid_q),
    .sfr_hit(sfr_hit),
    .prog(prog),
    .wdt_option_en(wdt_option_en),
    .wdt_reset_req(wdt_reset_req),
    .data_ready(data_ready),
    .sys_area(sys_area)
  );

  drp_core_model u_drp_core_model (
    .clock(clock),
    .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q),
    .sfr_rvalid_q(sfr_rvalid_q)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic load_byte(input logic [19:0] a, input logic [7:0] b);
    @(negedge clock);
    prog = '{en: 1'b1, addr: a, data: b};
    @(negedge clock);
    prog = '{en: 1'b0, addr: ~a, data: ~b};
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [3:0] exp);
    u_drp_core_model.rd(a, q, v);
    check(v, 1);
    check(q, exp);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (wdt_reset_req === 1'b1)
      wdt_hits++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end

  initial
  begin
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    for (int i = 0; i < N; i++)
    begin
      load_byte(r_addr[i], r_byte[i]);
      u_drp_core_model.set_addr(r_addr[i]);
      check(data_ready, 1);
      check(sys_area, r_sys[i]);
      rd_chk(DRP_OFF_READ_LOW, r_exp[i][3:0]);
      rd_chk(DRP_OFF_READ_HIGH, r_exp[i][7:4]);
      rd_chk(DRP_OFF_READ_LOW, r_exp[i][3:0]);
      for (int k = 0; k < 4; k++)
        rd_chk(DRP_OFF_NIB0 + 5'(k), r_addr[i][4 * k +: 4]);
      rd_chk(DRP_OFF_TOP, {3'b000, r_addr[i][16]});
    end
    $display("test rows done");
    u_drp_core_model.set_addr(r_addr[1]);
    // hit flag sampled while the request stands
    fork
      u_drp_core_model.rd(5'h17, q, v);
      begin
        @(negedge clock);
        @(posedge clock);
        check(sfr_hit, 0);
      end
    join
    check(v, 0);
    fork
      u_drp_core_model.rd(DRP_OFF_READ_LOW, q, v);
      begin
        @(negedge clock);
        @(posedge clock);
        check(sfr_hit, 1);
      end
    join
    check(q, r_exp[1][3:0]);
    u_drp_core_model.wr(DRP_OFF_READ_LOW, 4'h0);
    u_drp_core_model.put(1'b1, 1'b1, DRP_OFF_NIB0, 4'hf);
    rd_chk(DRP_OFF_NIB0, r_addr[1][3:0]);
    rd_chk(DRP_OFF_READ_LOW, r_exp[1][3:0]);
    $display("test refused done");
    repeat (40) @(negedge clock);
    check(wdt_hits, 0);
    wdt_option_en = 1'b1;
    for (int k = 0; k < 24; k++)
      u_drp_core_model.wr(DRP_OFF_READ_HIGH, 4'(k));
    check(wdt_hits, 0);
    repeat (20) @(negedge clock);
    check(wdt_hits, 1);
    wdt_option_en = 1'b0;
    $display("test watchdog done");
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    check(sfr_rvalid_q, 0);
    check(sfr_rdata_q, 0);
    nrst = 1'b1;
    rd_chk(DRP_OFF_READ_HIGH, r_exp[1][7:4]);
    check(data_ready, 0);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire

// *** verilog/drp_pkg.sv ***
`default_nettype none
package drp_pkg;

  // widths of the core's special-register port and of the data rom
  localparam int unsigned DRP_NIB_W = 4;
  localparam int unsigned DRP_SFR_AW = 5;
  localparam int unsigned DRP_ADDR_W = 20;
  localparam int unsigned DRP_BYTE_W = 8;
  localparam int unsigned DRP_ADDR_NIBS = 4;
  localparam int unsigned DRP_TOP_BIT = 0;

  // special-register locations of this block
  localparam logic [4:0] DRP_OFF_NIB0 = 5'h18;
  localparam logic [4:0] DRP_OFF_NIB1 = 5'h19;
  localparam logic [4:0] DRP_OFF_NIB2 = 5'h1a;
  localparam logic [4:0] DRP_OFF_NIB3 = 5'h1b;
  localparam logic [4:0] DRP_OFF_READ_LOW = 5'h1c;
  localparam logic [4:0] DRP_OFF_READ_HIGH = 5'h1d;
  localparam logic [4:0] DRP_OFF_TOP = 5'h1e;

  // data rom capacity and reserved system area
  localparam logic [19:0] DRP_ROM_CAP = 20'h1_e000;
  localparam logic [19:0] DRP_SYS_LO = 20'h1_dfc0;
  localparam logic [19:0] DRP_SYS_HI = 20'h1_dfff;
  localparam int unsigned DRP_ROM_DEPTH = 122880;

  // data ready time in system clock periods
  localparam int unsigned DRP_TDRR_CYC = 2;
  // watchdog period in system clock periods: 256*256*16
  localparam int unsigned DRP_WDT_PERIOD_CYC = 1048576;

  localparam logic [3:0] DRP_NIB_ZERO = 4'h0;
  localparam logic [7:0] DRP_BYTE_BLANK = 8'h00;

  // one core access to the special-register space
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [3:0] wdata;
  } drp_sfr_req_t;

  // otp programming port
  typedef struct packed {
    logic en;
    logic [19:0] addr;
    logic [7:0] data;
  } drp_prog_t;

  // watchdog states
  typedef enum logic [2:0] {
    DRP_WDT_OFF = 3'b001,
    DRP_WDT_RUN = 3'b010,
    DRP_WDT_FIRE = 3'b100
  } drp_wdt_state_t;

endpackage
`default_nettype wire

// *** verilog/drp_read_port.sv ***
// Behaviour
// - The 20-bit rom byte address takes bits 16 to 0 from the five address registers, register 0 lowest; bits 19 to 17 are zero.
// - Address registers 0 to 3 sit at 18H to 1BH, the top one at 1EH with only bit 0 kept.
// - Reading location 1CH returns bits 3 to 0 of the addressed rom byte.
// - Reading location 1DH returns bits 7 to 4 of the addressed rom byte.
// - Data is valid no later than two clock periods after the address was last set.
// - A write to 1DH restarts the watchdog count when the watchdog option is on.
// - The rom holds byte-wide words, at most 120K of them within the 20-bit space.
// - The last 64 bytes are a system area that software avoids; hardware only reports it.
// - Address and data registers have no defined value after reset.
// - The watchdog exists only under its option and its overflow requests a reset.
`timescale 1ns/1ps
`default_nettype none
module drp_read_port
  import drp_pkg::*;
#(
  parameter int unsigned WDT_PERIOD_CYC = DRP_WDT_PERIOD_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // core special-register access
  input wire drp_pkg::drp_sfr_req_t sfr_req,
  output logic [3:0] sfr_rdata_q,
  output logic sfr_rvalid_q,
  output logic sfr_hit,
  // otp programming
  input wire drp_pkg::drp_prog_t prog,
  // watchdog
  input wire logic wdt_option_en,
  output logic wdt_reset_req,
  // status
  output logic data_ready,
  output logic sys_area
);
  import drp_pkg::*;

  // decode of a special-register location to an address nibble index
  function automatic logic [2:0] nib_index(input logic [4:0] a);
    logic [2:0] idx;
    idx = 3'd7;
    case (a)
      DRP_OFF_NIB0: idx = 3'd0;
      DRP_OFF_NIB1: idx = 3'd1;
      DRP_OFF_NIB2: idx = 3'd2;
      DRP_OFF_NIB3: idx = 3'd3;
      DRP_OFF_TOP: idx = 3'd4;
      default: idx = 3'd7;
    endcase
    return idx;
  endfunction

  function automatic logic is_mine(input logic [4:0] a);
    return (a >= DRP_OFF_NIB0) && (a <= DRP_OFF_TOP);
  endfunction

  // address nibble registers
  logic [3:0] nib_q [0:DRP_ADDR_NIBS-1];
  logic top_q;

  wire [2:0] wr_idx_w = nib_index(sfr_req.addr);
  wire [2:0] rd_idx_w = nib_index(sfr_req.addr);
  wire wr_w = sfr_req.wr && !sfr_req.rd;
  wire rd_w = sfr_req.rd && !sfr_req.wr;
  wire addr_wr_w = wr_w && (wr_idx_w != 3'd7);
  wire top_wr_w = wr_w && (sfr_req.addr == DRP_OFF_TOP);
  wire high_wr_w = wr_w && (sfr_req.addr == DRP_OFF_READ_HIGH);

  genvar gi;
  generate
    for (gi = 0; gi < DRP_ADDR_NIBS; gi++)
    begin : g_nib
      wire sel_w = wr_w && (wr_idx_w == 3'(gi));
      always_ff @(posedge clock)
      begin
        if (sel_w)
          nib_q[gi] <= sfr_req.wdata;
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (top_wr_w)
      top_q <= sfr_req.wdata[DRP_TOP_BIT];
  end

  wire [19:0] rom_addr_w = {3'b000, top_q, nib_q[3], nib_q[2], nib_q[1], nib_q[0]};

  logic [DRP_ADDR_NIBS:0] loaded_q;
  wire [DRP_ADDR_NIBS:0] loaded_d = loaded_q | ({4'h0, addr_wr_w} << wr_idx_w);
  wire all_loaded_w = &loaded_q;

  // address registers keep no reset value, so readiness waits for all five to be loaded
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      loaded_q <= '0;
    else
      loaded_q <= loaded_d;
  end

  // rom array
  wire [7:0] rom_byte_w;
  wire [19:0] rom_echo_w;

  drp_rom_mem u_rom (
    .clock(clock),
    .prog(prog),
    .rd_addr(rom_addr_w),
    .rd_data_q(rom_byte_w),
    .rd_echo_q(rom_echo_w)
  );

  assign data_ready = all_loaded_w && (rom_echo_w == rom_addr_w);

  assign sys_area = (rom_addr_w >= DRP_SYS_LO) && (rom_addr_w <= DRP_SYS_HI);

  // watchdog
  wire [20:0] wdt_count_w;

  drp_watchdog #(
    .PERIOD_CYC(WDT_PERIOD_CYC)
  ) u_wdt (
    .clock(clock),
    .nrst(nrst),
    .option_en(wdt_option_en),
    .kick(high_wr_w),
    .count_q(wdt_count_w),
    .reset_req(wdt_reset_req)
  );

  // read selection
  wire [3:0] top_rd_w = {3'b000, top_q};
  wire [3:0] nib_rd_w = (rd_idx_w < 3'd4) ? nib_q[rd_idx_w[1:0]] : DRP_NIB_ZERO;
  logic [3:0] rdata_w;

  assign sfr_hit = is_mine(sfr_req.addr);

  always_comb
  begin
    rdata_w = DRP_NIB_ZERO;
    case (sfr_req.addr)
      DRP_OFF_READ_LOW: rdata_w = rom_byte_w[3:0];
      DRP_OFF_READ_HIGH: rdata_w = rom_byte_w[7:4];
      DRP_OFF_TOP: rdata_w = top_rd_w;
      default: rdata_w = nib_rd_w;
    endcase
  end

  // read returns data without side effect
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sfr_rdata_q <= DRP_NIB_ZERO;
      sfr_rvalid_q <= 1'b0;
    end
    else
    begin
      sfr_rvalid_q <= rd_w && sfr_hit;
      if (rd_w && sfr_hit)
        sfr_rdata_q <= rdata_w;
    end
  end

  property p_addr_low_nibble;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_NIB0) |=> (rom_addr_w[3:0] == $past(sfr_req.wdata));
  endproperty
  a_addr_low_nibble: assert property (p_addr_low_nibble)
    else $error("nibble 0 write did not reach address bits 3:0");

  property p_addr_nib3;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_NIB3) |=> (rom_addr_w[15:12] == $past(sfr_req.wdata));
  endproperty
  a_addr_nib3: assert property (p_addr_nib3)
    else $error("nibble 3 write did not reach address bits 15:12");

  property p_top_one_bit;
    @(posedge clock) disable iff (!nrst)
    (rd_w && sfr_req.addr == DRP_OFF_TOP) |=> (sfr_rvalid_q && sfr_rdata_q[3:1] == 3'b000);
  endproperty
  a_top_one_bit: assert property (p_top_one_bit)
    else $error("top address register read showed unimplemented bits");

  property p_read_low;
    @(posedge clock) disable iff (!nrst)
    (rd_w && sfr_req.addr == DRP_OFF_READ_LOW) |=> (sfr_rdata_q == $past(rom_byte_w[3:0]));
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("low data read did not return byte bits 3:0");

  property p_read_high;
    @(posedge clock) disable iff (!nrst)
    (rd_w && sfr_req.addr == DRP_OFF_READ_HIGH) |=> (sfr_rdata_q == $past(rom_byte_w[7:4]));
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("high data read did not return byte bits 7:4");

  property p_ready_time;
    @(posedge clock) disable iff (!nrst)
    addr_wr_w ##1 (!addr_wr_w && all_loaded_w) |=> data_ready;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("data not ready two cycles after address set");

  property p_wdt_kick;
    @(posedge clock) disable iff (!nrst)
    (high_wr_w && wdt_option_en) ##1 wdt_option_en |-> (wdt_count_w == 21'd0) && !wdt_reset_req;
  endproperty
  a_wdt_kick: assert property (p_wdt_kick)
    else $error("high data write did not restart watchdog");

  property p_beyond_cap;
    @(posedge clock) disable iff (!nrst)
    (rom_addr_w >= DRP_ROM_CAP) && !prog.en |=> (rom_byte_w == DRP_BYTE_BLANK);
  endproperty
  a_beyond_cap: assert property (p_beyond_cap)
    else $error("read beyond rom capacity returned data");

  property p_read_no_effect;
    @(posedge clock) disable iff (!nrst)
    (rd_w && !addr_wr_w) |=> $stable(rom_addr_w);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("read changed the rom address");

  property p_addr_nib1;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_NIB1) |=> (rom_addr_w[7:4] == $past(sfr_req.wdata));
  endproperty
  a_addr_nib1: assert property (p_addr_nib1)
    else $error("nibble 1 write did not reach address bits 7:4");

  property p_addr_nib2;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_NIB2) |=> (rom_addr_w[11:8] == $past(sfr_req.wdata));
  endproperty
  a_addr_nib2: assert property (p_addr_nib2)
    else $error("nibble 2 write did not reach address bits 11:8");

  property p_addr_top;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_TOP)
      |=> (rom_addr_w[16] == $past(sfr_req.wdata[DRP_TOP_BIT]));
  endproperty
  a_addr_top: assert property (p_addr_top)
    else $error("top register write did not reach address bit 16");

  property p_read_nib2;
    @(posedge clock) disable iff (!nrst)
    (rd_w && sfr_req.addr == DRP_OFF_NIB2) |=> (sfr_rdata_q == $past(nib_q[2]));
  endproperty
  a_read_nib2: assert property (p_read_nib2)
    else $error("address register read did not return its nibble");

  property p_rd_both;
    @(posedge clock) disable iff (!nrst)
    (sfr_req.wr && sfr_req.rd) |=> (!sfr_rvalid_q && $stable(rom_addr_w));
  endproperty
  a_rd_both: assert property (p_rd_both)
    else $error("combined read and write strobe was not ignored");

  property p_rd_outside;
    @(posedge clock) disable iff (!nrst)
    (rd_w && !sfr_hit) |=> !sfr_rvalid_q;
  endproperty
  a_rd_outside: assert property (p_rd_outside)
    else $error("read outside this block answered");

  property p_rdata_hold;
    @(posedge clock) disable iff (!nrst)
    !(rd_w && sfr_hit) |=> $stable(sfr_rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_low_write_ignored;
    @(posedge clock) disable iff (!nrst)
    (wr_w && sfr_req.addr == DRP_OFF_READ_LOW) |=> $stable(rom_addr_w);
  endproperty
  a_low_write_ignored: assert property (p_low_write_ignored)
    else $error("write to low data register changed the address");

  property p_wdt_idle;
    @(posedge clock) disable iff (!nrst)
    !wdt_option_en ##1 !wdt_option_en |=> (wdt_count_w == 21'd0);
  endproperty
  a_wdt_idle: assert property (p_wdt_idle)
    else $error("watchdog counted while not enabled");

endmodule
`default_nettype wire

// *** verilog/drp_rom_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module drp_rom_mem
  import drp_pkg::*;
(
  // clock
  input wire logic clock,
  // programming
  input wire drp_pkg::drp_prog_t prog,
  // read
  input wire logic [19:0] rd_addr,
  output logic [7:0] rd_data_q,
  output logic [19:0] rd_echo_q
);
  import drp_pkg::*;

  logic [7:0] mem [0:DRP_ROM_DEPTH-1];
  wire in_range_w = (rd_addr < DRP_ROM_CAP);
  wire prog_ok_w = prog.en && (prog.addr < DRP_ROM_CAP);

  always_ff @(posedge clock)
  begin
    if (prog_ok_w)
    begin
      mem[prog.addr[16:0]] <= prog.data;
    end
  end

  // read every cycle; beyond capacity returns a blank byte
  always_ff @(posedge clock)
  begin
    rd_data_q <= in_range_w ? mem[rd_addr[16:0]] : DRP_BYTE_BLANK;
    rd_echo_q <= rd_addr;
  end

endmodule
`default_nettype wire

// *** verilog/drp_watchdog.sv ***
`timescale 1ns/1ps
`default_nettype none
module drp_watchdog
  import drp_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = DRP_WDT_PERIOD_CYC
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic option_en,
  input wire logic kick,
  // status
  output logic [20:0] count_q,
  output logic reset_req
);
  import drp_pkg::*;

  drp_wdt_state_t state_q;
  drp_wdt_state_t state_d;
  wire at_end_w = (count_q == 21'(PERIOD_CYC - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DRP_WDT_OFF: state_d = option_en ? DRP_WDT_RUN : DRP_WDT_OFF;
      DRP_WDT_RUN:
      begin
        if (!option_en)
          state_d = DRP_WDT_OFF;
        else if (at_end_w && !kick)
          state_d = DRP_WDT_FIRE;
      end
      DRP_WDT_FIRE: state_d = option_en ? DRP_WDT_RUN : DRP_WDT_OFF;
      default: state_d = DRP_WDT_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= DRP_WDT_OFF;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != DRP_WDT_RUN || kick || at_end_w)
        count_q <= '0;
      else
        count_q <= count_q + 21'd1;
    end
  end

  assign reset_req = (state_q == DRP_WDT_FIRE);

  property p_wdt_overflow;
    @(posedge clock) disable iff (!nrst)
    (state_q == DRP_WDT_RUN && option_en && at_end_w && !kick) |=> reset_req;
  endproperty
  a_wdt_overflow: assert property (p_wdt_overflow)
    else $error("watchdog overflow did not request reset");

  property p_wdt_absent;
    @(posedge clock) disable iff (!nrst)
    !option_en ##1 !option_en |-> !reset_req;
  endproperty
  a_wdt_absent: assert property (p_wdt_absent)
    else $error("watchdog fired while not enabled");

endmodule
`default_nettype wire
